// >>> core/mshc_pkg.sv
// Package with register map, field layout, states and carrier types for the startup handoff block.
package mshc_pkg;

  // Register offsets are word indexes; the byte address is four times the index.
  localparam logic [7:0]  IDX_STARTUP  = 8'h84;   // Startup configuration index.
  localparam logic [7:0]  IDX_LOOP     = 8'h86;   // Closed-loop configuration index.
  localparam logic [7:0]  IDX_STATUS   = 8'h8A;   // Read-only sequencer status index.
  localparam logic [31:0] RST_STARTUP  = 32'h0000_0000; // Startup register reset value.
  localparam logic [31:0] RST_LOOP     = 32'h0000_0000; // Closed-loop register reset value.

  // Startup configuration field positions.
  localparam int OL_ACC2_LSB  = 13;  // Second open-loop acceleration, 5 bits.
  localparam int XFER_FQ_LSB  = 8;   // Handoff frequency code, 5 bits.
  localparam int AUTO_BIT     = 7;   // Automatic handoff select.
  localparam int FIRST_ZERO   = 6;   // First cycle at 0 Hz select.
  localparam int MIN_DUTY_LSB = 2;   // Minimum duty code, 4 bits.
  localparam int XFER_CYC_LSB = 0;   // Handoff cycle count code, 2 bits.
  localparam int INIT_RT_LSB  = 0;   // Slow first cycle frequency code, 4 bits.

  // Closed-loop configuration field positions.
  localparam int COMM_LSB     = 29;  // Commutation scheme, 2 bits.
  localparam int RAMP_UP_LSB  = 24;  // Closed-loop acceleration, 5 bits.
  localparam int DN_SRC_BIT   = 23;  // Deceleration source select.
  localparam int RAMP_DN_LSB  = 18;  // Closed-loop deceleration, 5 bits.

  // Status register field positions.
  localparam int ST_STATE_LSB = 0;   // One-hot sequencer state, 4 bits.
  localparam int ST_BADCOMM   = 4;   // Invalid commutation code seen.
  localparam int ST_CNT_LSB   = 8;   // Handoff cycles counted so far, 5 bits.

  // Commutation codes.
  localparam logic [1:0] COMM_FIXED = 2'h0;  // Fixed 120 degree.
  localparam logic [1:0] COMM_VAR   = 2'h1;  // Variable 120 to 150 degree.

  // Saturating code that means no acceleration limit.
  localparam logic [4:0] RATE_NOLIMIT = 5'h1F;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_OPEN    = 4'h2,
    ST_HANDOFF = 4'h4,
    ST_CLOSED  = 4'h8
  } mshc_state_e;

  // Decoded settings handed to the motor control datapath.
  typedef struct packed {
    logic [24:0] openloop_second_accel; // Units of 0.001 Hz/s2.
    logic [9:0]  loop_transfer_freq;    // Units of 1 Hz.
    logic        auto_transfer;         // Automatic handoff chosen.
    logic [14:0] initial_cycle_rate;    // Units of 0.01 Hz; zero when 0 Hz chosen.
    logic [9:0]  min_duty;              // Units of 0.1 percent.
    logic [4:0]  transfer_cycle_count;  // Handoff cycles.
    logic        commutation_variable;  // Variable commutation chosen.
    logic [24:0] feedback_ramp_up;      // Units of 0.001 V/s.
    logic [24:0] feedback_ramp_down;    // Effective deceleration, 0.001 V/s.
  } mshc_set_s;

endpackage

// >>> core/mshc_core.sv
// Startup, handoff and closed-loop configuration block with its register slave and sequencer.
module mshc_core
  import mshc_pkg::*;
(
  input  wire logic               clk,                // System clock, 20 MHz.
  input  wire logic               nrst,               // Synchronous reset, active low.
  input  wire logic [9:0]         avs_address,        // Byte address.
  input  wire logic               avs_read,           // Read request.
  input  wire logic               avs_write,          // Write request.
  input  wire logic [31:0]        avs_writedata,      // Write data.
  input  wire logic [3:0]         avs_byteenable,     // Write byte lanes.
  output logic      [31:0]        avs_readdata,       // Read data.
  output logic                    avs_waitrequest,    // Stall until the access completes.
  input  wire logic               run_request,        // Motor run command.
  input  wire logic [9:0]         elec_freq_hz,       // Present electrical frequency.
  input  wire logic               auto_handoff_ready, // Automatic handoff point reached.
  input  wire logic               elec_cycle_done,    // Pulse per electrical cycle.
  input  wire logic [9:0]         duty_request,       // Requested duty, 0.1 percent units.
  output mshc_pkg::mshc_set_s     settings,           // Decoded settings.
  output logic      [9:0]         duty_out,           // Applied duty.
  output logic                    closed_loop,        // Closed-loop commutation active.
  output logic                    in_handoff          // Handoff cycles running.
);
  import mshc_pkg::*;

  // Shared rate table for Hz/s2 and V/s fields, in thousandths.
  function automatic logic [24:0] rate_decode(input logic [4:0] code);
    case (code)
      5'h00: rate_decode = 25'h0000005;
      5'h01: rate_decode = 25'h000000A;
      5'h02: rate_decode = 25'h0000019;
      5'h03: rate_decode = 25'h0000032;
      5'h04: rate_decode = 25'h0000064;
      5'h05: rate_decode = 25'h00000FA;
      5'h06: rate_decode = 25'h00001F4;
      5'h07: rate_decode = 25'h00003E8;
      5'h08: rate_decode = 25'h00009C4;
      5'h09: rate_decode = 25'h0001388;
      5'h0A: rate_decode = 25'h0001D4C;
      5'h0B: rate_decode = 25'h0002710;
      5'h0C: rate_decode = 25'h00030D4;
      5'h0D: rate_decode = 25'h0003A98;
      5'h0E: rate_decode = 25'h0004E20;
      5'h0F: rate_decode = 25'h0007530;
      5'h10: rate_decode = 25'h0009C40;
      5'h11: rate_decode = 25'h000C350;
      5'h12: rate_decode = 25'h000EA60;
      5'h13: rate_decode = 25'h00124F8;
      5'h14: rate_decode = 25'h00186A0;
      5'h15: rate_decode = 25'h001E848;
      5'h16: rate_decode = 25'h00249F0;
      5'h17: rate_decode = 25'h002AB98;
      5'h18: rate_decode = 25'h0030D40;
      5'h19: rate_decode = 25'h003D090;
      5'h1A: rate_decode = 25'h00493E0;
      5'h1B: rate_decode = 25'h0061A80;
      5'h1C: rate_decode = 25'h007A120;
      5'h1D: rate_decode = 25'h00B71B0;
      5'h1E: rate_decode = 25'h00F4240;
      default: rate_decode = 25'h1F3FC18; // Unlimited, 32767 full units.
    endcase
  endfunction

  // Handoff threshold table in Hz; top codes continue in 50 Hz steps.
  function automatic logic [9:0] xfer_decode(input logic [4:0] code);
    case (code)
      5'h00: xfer_decode = 10'h001;
      5'h01: xfer_decode = 10'h004;
      5'h02: xfer_decode = 10'h008;
      5'h03: xfer_decode = 10'h00C;
      5'h04: xfer_decode = 10'h010;
      5'h05: xfer_decode = 10'h014;
      5'h06: xfer_decode = 10'h018;
      5'h07: xfer_decode = 10'h01C;
      5'h08: xfer_decode = 10'h020;
      5'h09: xfer_decode = 10'h024;
      5'h0A: xfer_decode = 10'h028;
      5'h0B: xfer_decode = 10'h02D;
      5'h0C: xfer_decode = 10'h032;
      5'h0D: xfer_decode = 10'h037;
      5'h0E: xfer_decode = 10'h03C;
      5'h0F: xfer_decode = 10'h041;
      5'h10: xfer_decode = 10'h046;
      5'h11: xfer_decode = 10'h04B;
      5'h12: xfer_decode = 10'h050;
      5'h13: xfer_decode = 10'h055;
      5'h14: xfer_decode = 10'h05A;
      5'h15: xfer_decode = 10'h064;
      5'h16: xfer_decode = 10'h096;
      5'h17: xfer_decode = 10'h0C8;
      5'h18: xfer_decode = 10'h0FA;
      5'h19: xfer_decode = 10'h12C;
      5'h1A: xfer_decode = 10'h15E;
      5'h1B: xfer_decode = 10'h190;
      5'h1C: xfer_decode = 10'h1C2;
      5'h1D: xfer_decode = 10'h1F4;
      5'h1E: xfer_decode = 10'h226;
      default: xfer_decode = 10'h258;
    endcase
  endfunction

  // Minimum duty table in tenths of a percent.
  function automatic logic [9:0] duty_decode(input logic [3:0] code);
    case (code)
      4'h0: duty_decode = 10'h000;
      4'h1: duty_decode = 10'h00F;
      4'h2: duty_decode = 10'h019;
      4'h3: duty_decode = 10'h01E;
      4'h4: duty_decode = 10'h028;
      4'h5: duty_decode = 10'h032;
      4'h6: duty_decode = 10'h03C;
      4'h7: duty_decode = 10'h046;
      4'h8: duty_decode = 10'h050;
      4'h9: duty_decode = 10'h05A;
      4'hA: duty_decode = 10'h064;
      4'hB: duty_decode = 10'h078;
      4'hC: duty_decode = 10'h096;
      4'hD: duty_decode = 10'h0AF;
      4'hE: duty_decode = 10'h0C8;
      default: duty_decode = 10'h0FA;
    endcase
  endfunction

  // First cycle frequency table in hundredths of a Hz.
  function automatic logic [14:0] init_decode(input logic [3:0] code);
    case (code)
      4'h0: init_decode = 15'h0005;
      4'h1: init_decode = 15'h000A;
      4'h2: init_decode = 15'h0019;
      4'h3: init_decode = 15'h0032;
      4'h4: init_decode = 15'h0064;
      4'h5: init_decode = 15'h00C8;
      4'h6: init_decode = 15'h012C;
      4'h7: init_decode = 15'h01F4;
      4'h8: init_decode = 15'h03E8;
      4'h9: init_decode = 15'h05DC;
      4'hA: init_decode = 15'h07D0;
      4'hB: init_decode = 15'h09C4;
      4'hC: init_decode = 15'h1388;
      4'hD: init_decode = 15'h2710;
      4'hE: init_decode = 15'h3A98;
      default: init_decode = 15'h4E20;
    endcase
  endfunction

  // Merge write data into a register by byte lane.
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old_v[i*8 +: 8] = be[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
    lane_merge = old_v;
  endfunction

  logic [31:0] startup_config_b_reg;  // Startup configuration.
  logic [31:0] startup_config_b_next; // Its next value.
  logic [31:0] speed_loop_config_a_reg;  // Closed-loop configuration.
  logic [31:0] speed_loop_config_a_next; // Its next value.
  logic [3:0]  init_code_reg;         // Slow first cycle code, held in its own word.
  logic [3:0]  init_code_next;        // Its next value.
  logic [31:0] rdata_reg;             // Read data register.
  logic [31:0] rdata_next;            // Its next value.
  logic        wait_reg;              // Waitrequest register.
  logic        wait_next;             // Its next value.
  logic [7:0]  word_idx;              // Register index from the byte address.
  logic [31:0] status_word;           // Live status view.
  logic        do_write;              // Write commits this edge.

  mshc_state_e state_reg;             // Sequencer state.
  mshc_state_e state_next;            // Its next value.
  logic [4:0]  cyc_reg;               // Handoff cycles counted.
  logic [4:0]  cyc_next;              // Its next value.
  logic        bad_comm_reg;          // Sticky invalid commutation flag.
  logic        bad_comm_next;         // Its next value.
  mshc_set_s   set_reg;               // Registered decoded settings.
  mshc_set_s   set_next;              // Its next value.
  logic [9:0]  duty_reg;              // Applied duty.
  logic [9:0]  duty_next;             // Its next value.
  logic        handoff_met;           // Handoff condition this cycle.

  assign word_idx = avs_address[9:2];
  assign status_word = {19'h00000, cyc_reg, 3'h0, bad_comm_reg, state_reg};
  // A request is taken on the edge where waitrequest is already low, so each access
  // stalls exactly one cycle; the read word is captured on the first cycle.
  assign do_write = avs_write && !wait_reg;

  // Register slave next state.
  always_comb begin
    startup_config_b_next = startup_config_b_reg;
    speed_loop_config_a_next = speed_loop_config_a_reg;
    init_code_next = init_code_reg;
    rdata_next = rdata_reg;
    wait_next = 1'b1;
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
    end
    if (avs_read && wait_reg) begin
      case (word_idx)
        IDX_STARTUP: rdata_next = startup_config_b_reg;
        IDX_LOOP: rdata_next = speed_loop_config_a_reg;
        IDX_STATUS: rdata_next = status_word;
        IDX_STARTUP + 8'h01: rdata_next = {28'h0000000, init_code_reg};
        default: rdata_next = 32'h0000_0000; // Unmapped words read as zero.
      endcase
    end
    if (do_write) begin
      case (word_idx)
        IDX_STARTUP: startup_config_b_next = lane_merge(startup_config_b_reg, avs_writedata,
                                                        avs_byteenable);
        IDX_LOOP: speed_loop_config_a_next = lane_merge(speed_loop_config_a_reg, avs_writedata,
                                                        avs_byteenable);
        IDX_STARTUP + 8'h01: init_code_next = avs_byteenable[0] ? avs_writedata[INIT_RT_LSB +: 4] :
                                              init_code_reg;
        default: ; // Writes to status or unmapped words are ignored.
      endcase
    end
  end

  // Register slave storage.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      startup_config_b_reg <= RST_STARTUP;
      speed_loop_config_a_reg <= RST_LOOP;
      init_code_reg <= 4'h0;
      rdata_reg <= 32'h0000_0000;
      wait_reg <= 1'b1;
    end else begin
      startup_config_b_reg <= startup_config_b_next;
      speed_loop_config_a_reg <= speed_loop_config_a_next;
      init_code_reg <= init_code_next;
      rdata_reg <= rdata_next;
      wait_reg <= wait_next;
    end
  end

  // Decode every field into datapath units.
  always_comb begin
    set_next.openloop_second_accel = rate_decode(startup_config_b_reg[OL_ACC2_LSB +: 5]);
    set_next.loop_transfer_freq = xfer_decode(startup_config_b_reg[XFER_FQ_LSB +: 5]);
    set_next.auto_transfer = startup_config_b_reg[AUTO_BIT];
    // Zero select overrides the coded first cycle rate.
    set_next.initial_cycle_rate = startup_config_b_reg[FIRST_ZERO] ? 15'h0000 :
                                  init_decode(init_code_reg);
    set_next.min_duty = duty_decode(startup_config_b_reg[MIN_DUTY_LSB +: 4]);
    set_next.transfer_cycle_count = 5'h03 << startup_config_b_reg[XFER_CYC_LSB +: 2];
    // Invalid codes fall back to the safe fixed scheme.
    set_next.commutation_variable = speed_loop_config_a_reg[COMM_LSB +: 2] == COMM_VAR;
    set_next.feedback_ramp_up = rate_decode(speed_loop_config_a_reg[RAMP_UP_LSB +: 5]);
    set_next.feedback_ramp_down = speed_loop_config_a_reg[DN_SRC_BIT] ?
                                  rate_decode(speed_loop_config_a_reg[RAMP_UP_LSB +: 5]) :
                                  rate_decode(speed_loop_config_a_reg[RAMP_DN_LSB +: 5]);
  end

  // Sequencer next state.
  always_comb begin
    state_next = state_reg;
    cyc_next = cyc_reg;
    bad_comm_next = bad_comm_reg || (speed_loop_config_a_reg[COMM_LSB +: 2] != COMM_FIXED &&
                                     speed_loop_config_a_reg[COMM_LSB +: 2] != COMM_VAR);
    handoff_met = set_reg.auto_transfer ? auto_handoff_ready :
                  elec_freq_hz >= set_reg.loop_transfer_freq;
    duty_next = duty_request;
    case (state_reg)
      ST_IDLE: begin
        cyc_next = 5'h00;
        duty_next = 10'h000;
        if (run_request) begin
          state_next = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (handoff_met) begin
          state_next = ST_HANDOFF;
        end
      end
      ST_HANDOFF: begin
        // Count whole cycles; the last one completes the transfer.
        if (elec_cycle_done) begin
          cyc_next = cyc_reg + 5'h01;
          if (cyc_reg + 5'h01 >= set_reg.transfer_cycle_count) begin
            state_next = ST_CLOSED;
          end
        end
      end
      ST_CLOSED: begin
        // Stay in closed loop until run is withdrawn; the floor is applied below.
        state_next = ST_CLOSED;
      end
      default: state_next = ST_IDLE;
    endcase
    if (!run_request) begin
      state_next = ST_IDLE;
    end
    // Clamp from the edge that enters closed loop, against the floor that the settings
    // register takes at the same edge, so no closed-loop cycle runs below it.
    if (state_next == ST_CLOSED && duty_request < set_next.min_duty) begin
      duty_next = set_next.min_duty;
    end
  end

  // Sequencer and settings registers.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      cyc_reg <= 5'h00;
      bad_comm_reg <= 1'b0;
      set_reg <= '0;
      duty_reg <= 10'h000;
    end else begin
      state_reg <= state_next;
      cyc_reg <= cyc_next;
      bad_comm_reg <= bad_comm_next;
      set_reg <= set_next;
      duty_reg <= duty_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign settings = set_reg;
  assign duty_out = duty_reg;
  assign closed_loop = state_reg[3]; // One-hot bit of the closed state.
  assign in_handoff = state_reg[2];  // One-hot bit of the handoff state.

endmodule

// >>> verification/mshc_core_monitor.sv
// Concurrent checks on the ports of the startup handoff configuration block.
module mshc_core_monitor
  import mshc_pkg::*;
(
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic [9:0]         avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  input wire logic [3:0]         avs_byteenable,
  input wire logic               avs_waitrequest,
  input wire logic               run_request,
  input wire logic               elec_cycle_done,
  input wire mshc_pkg::mshc_set_s settings,
  input wire logic [9:0]         duty_out,
  input wire logic               closed_loop,
  input wire logic               in_handoff
);
  timeunit 1ns;
  timeprecision 1ps;

  logic wr_st; // A full-word write to the startup word is taken this cycle.
  logic wr_lp; // A full-word write to the closed-loop word is taken this cycle.

  // Decoded settings lag the register by one cycle, so checks look two edges ahead.
  assign wr_st = avs_write && !avs_waitrequest && avs_address[9:2] == IDX_STARTUP
                 && avs_byteenable == 4'hF;
  assign wr_lp = avs_write && !avs_waitrequest && avs_address[9:2] == IDX_LOOP
                 && avs_byteenable == 4'hF;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  AST_WAIT_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("Bus request not answered after one wait cycle.");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("Wait request stayed low for more than one cycle.");
  AST_ACC_NOLIMIT: assert property (wr_st && avs_writedata[17:13] == RATE_NOLIMIT
    |=> ##1 settings.openloop_second_accel == 25'h1F3FC18)
    else $error("Unlimited acceleration code did not decode to the maximum.");
  AST_CYC_COUNT: assert property (wr_st
    |=> ##1 settings.transfer_cycle_count == (5'h03 << $past(avs_writedata[1:0], 2)))
    else $error("Handoff cycle count decode wrong.");
  AST_AUTO_SEL: assert property (wr_st
    |=> ##1 settings.auto_transfer == $past(avs_writedata[AUTO_BIT], 2))
    else $error("Automatic handoff select not followed.");
  AST_FIRST_ZERO: assert property (wr_st && avs_writedata[FIRST_ZERO]
    |=> ##1 settings.initial_cycle_rate == 15'h0000)
    else $error("First cycle rate not zero when zero start selected.");
  AST_DUTY_MAX: assert property (wr_st && avs_writedata[5:2] == 4'hF
    |=> ##1 settings.min_duty == 10'h0FA)
    else $error("Top minimum duty code did not give 25 percent.");
  AST_COMM_SEL: assert property (wr_lp
    |=> ##1 settings.commutation_variable == ($past(avs_writedata[30:29], 2) == COMM_VAR))
    else $error("Commutation scheme decode wrong.");
  AST_DEC_SRC: assert property (wr_lp && avs_writedata[DN_SRC_BIT]
    |=> ##1 settings.feedback_ramp_down == settings.feedback_ramp_up)
    else $error("Deceleration did not reuse the acceleration rate.");
  AST_FLOOR: assert property (closed_loop |-> duty_out >= settings.min_duty)
    else $error("Closed-loop duty below the minimum.");
  AST_RUN_DROP: assert property (!run_request |=> !closed_loop && !in_handoff)
    else $error("Sequencer did not stop when run was withdrawn.");
  AST_CLOSE_CAUSE: assert property ($rose(closed_loop)
    |-> $past(in_handoff) && $past(elec_cycle_done))
    else $error("Closed loop entered without a handoff cycle.");

  // Main scenarios that the bench is expected to reach.
  cover property ($rose(in_handoff));
  cover property ($rose(closed_loop));
  cover property (wr_lp && avs_writedata[DN_SRC_BIT]);
endmodule

bind mshc_core mshc_core_monitor u_mon (.clk(clk), .nrst(nrst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .run_request(run_request), .elec_cycle_done(elec_cycle_done), .settings(settings),
  .duty_out(duty_out), .closed_loop(closed_loop), .in_handoff(in_handoff));

// >>> verification/tb.sv
// Self-checking bench for the startup handoff configuration block.
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb;
  import mshc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;            // System clock, 50 ns period.
  logic        nrst = 1'b0;           // Reset, held low at start.
  logic [9:0]  avs_address = 10'h000; // Bus signals driven by the bench.
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF; // Full words except the one single-lane write in t_loop.
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        run_request = 1'b0;    // Motor-side stimulus.
  logic [9:0]  elec_freq_hz = 10'h000;
  logic        auto_handoff_ready = 1'b0;
  logic        elec_cycle_done = 1'b0;
  logic [9:0]  duty_request = 10'h000;
  mshc_set_s   settings;
  logic [9:0]  duty_out;
  logic        closed_loop;
  logic        in_handoff;
  int          n_errors = 0;          // Mismatches seen.
  int          tests_run = 0;         // Comparisons made.
  int          cycles = 0;            // Watchdog count.
  logic [31:0] rd;                    // Last read data.

  mshc_core dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .run_request(run_request), .elec_freq_hz(elec_freq_hz),
    .auto_handoff_ready(auto_handoff_ready), .elec_cycle_done(elec_cycle_done),
    .duty_request(duty_request), .settings(settings), .duty_out(duty_out),
    .closed_loop(closed_loop), .in_handoff(in_handoff));

  // Free-running clock.
  always #25 clk = ~clk;

  // Watchdog: the whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      end_of_test();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One bus access; the request is held until wait request is sampled low.
  task automatic bus(input logic we, input logic [9:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= !we;
    // No cycle count is assumed; only the watchdog ends a wait that is never answered.
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // A free edge keeps two requests from being assigned in one time step.
    @(posedge clk);
  endtask

  // One electrical cycle pulse.
  task automatic pulse();
    elec_cycle_done <= 1'b1;
    @(posedge clk);
    elec_cycle_done <= 1'b0;
    @(posedge clk);
  endtask

  // Reset value of the closed-loop word and of the decoded settings.
  task automatic t_reset();
    bus(1'b0, 10'h218, 32'h0);
    `CHK(rd, 32'h0000_0000)
    `CHK(settings.openloop_second_accel, 25'h0000005)
    `CHK(settings.loop_transfer_freq, 10'h001)
    `CHK(settings.transfer_cycle_count, 5'h03)
    `CHK(settings.initial_cycle_rate, 15'h0005)
    `CHK(settings.feedback_ramp_up, 25'h0000005)
    `CHK(settings.feedback_ramp_down, 25'h0000005)
    `CHK(settings.commutation_variable, 1'b0)
    $display("test reset done");
  endtask

  // Writes a startup word and checks every decoded field and the read-back.
  task automatic chk_start(input logic [31:0] d, input logic [24:0] acc, input logic [9:0] fq,
                           input logic [9:0] dty, input logic [4:0] cyc, input logic [14:0] ini);
    bus(1'b1, 10'h210, d);
    repeat (2) @(posedge clk);
    `CHK(settings.openloop_second_accel, acc)
    `CHK(settings.loop_transfer_freq, fq)
    `CHK(settings.auto_transfer, d[7])
    `CHK(settings.initial_cycle_rate, ini)
    `CHK(settings.min_duty, dty)
    `CHK(settings.transfer_cycle_count, cyc)
    bus(1'b0, 10'h210, 32'h0);
    `CHK(rd, d)
  endtask

  // Boundary codes of the startup fields; first-cycle code Dh is 100 Hz.
  task automatic t_startup();
    bus(1'b1, 10'h214, 32'h0000_000D);
    chk_start(32'h0003_DB3F, 25'h00F4240, 10'h190, 10'h0FA, 5'h18, 15'h2710);
    chk_start(32'h0003_E0C6, 25'h1F3FC18, 10'h001, 10'h00F, 5'h0C, 15'h0000);
    chk_start(32'h0000_1531, 25'h0000005, 10'h064, 10'h096, 5'h06, 15'h2710);
    $display("test startup done");
  endtask

  // Commutation codes, ramp rates and both deceleration sources.
  task automatic t_loop();
    bus(1'b1, 10'h218, 32'h347C_0000);
    repeat (2) @(posedge clk);
    `CHK(settings.commutation_variable, 1'b1)
    `CHK(settings.feedback_ramp_up, 25'h00186A0)
    `CHK(settings.feedback_ramp_down, 25'h1F3FC18)
    bus(1'b1, 10'h218, 32'h478C_0000);
    repeat (2) @(posedge clk);
    `CHK(settings.commutation_variable, 1'b0)
    `CHK(settings.feedback_ramp_down, 25'h00003E8)
    bus(1'b0, 10'h228, 32'h0);
    `CHK(rd[ST_BADCOMM], 1'b1)
    bus(1'b0, 10'h218, 32'h0);
    `CHK(rd, 32'h478C_0000)
    // A single-lane write must change only the lowest byte of the word.
    avs_byteenable <= 4'h1;
    bus(1'b1, 10'h218, 32'hFFFF_FFA5);
    avs_byteenable <= 4'hF;
    bus(1'b0, 10'h218, 32'h0);
    `CHK(rd, 32'h478C_00A5)
    $display("test loop done");
  endtask

  // Automatic handoff ignores the frequency threshold and waits for the ready flag.
  task automatic t_auto();
    bus(1'b1, 10'h210, 32'h0000_0080);
    elec_freq_hz <= 10'h3FF;
    run_request <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(in_handoff, 1'b0)
    auto_handoff_ready <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(in_handoff, 1'b1)
    auto_handoff_ready <= 1'b0;
    run_request <= 1'b0;
    repeat (2) @(posedge clk);
    $display("test auto handoff done");
  endtask

  // Threshold handoff at 20 Hz, three cycles, 10 percent duty floor, stop and reset.
  task automatic t_seq();
    bus(1'b1, 10'h210, 32'h0000_0528);
    run_request <= 1'b1;
    elec_freq_hz <= 10'h013;
    duty_request <= 10'h032;
    repeat (4) @(posedge clk);
    `CHK(in_handoff, 1'b0)
    `CHK(duty_out, 10'h032)
    elec_freq_hz <= 10'h014;
    repeat (3) @(posedge clk);
    `CHK(in_handoff, 1'b1)
    repeat (2) pulse();
    `CHK(closed_loop, 1'b0)
    pulse();
    repeat (2) @(posedge clk);
    `CHK(closed_loop, 1'b1)
    `CHK(duty_out, 10'h064)
    duty_request <= 10'h12C;
    repeat (3) @(posedge clk);
    `CHK(duty_out, 10'h12C)
    run_request <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(closed_loop, 1'b0)
    `CHK(duty_out, 10'h000)
    bus(1'b0, 10'h3FC, 32'h0);
    `CHK(rd, 32'h0000_0000)
    // A second reset must bring the closed-loop word back to zero.
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    bus(1'b0, 10'h218, 32'h0);
    `CHK(rd, 32'h0000_0000)
    $display("test sequence done");
  endtask

  // Main sequence: reset for four cycles, then the scenarios in turn.
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_startup();
    t_loop();
    t_seq();
    t_auto();
    end_of_test();
  end
endmodule
